// ==== pkg/sic_regs.vh ====
// Purpose: constants of the solenoid interlock control block
// Assumes: 10 MHz pclk, APB byte addresses, 32-bit words
// Notes:   times are kept in their own unit, cycle counts derive from them
`ifndef SIC_REGS_VH
`define SIC_REGS_VH

// register byte offsets
`define SIC_CTRL_OFS        12'h000
`define SIC_STATUS_OFS      12'h004
`define SIC_CODE_OFS        12'h008

// control word fields
`define SIC_CTRL_UNLOCK_ON_ENERGISE 0
`define SIC_CTRL_GUARD_POSITION     1
`define SIC_CTRL_ONE_TIME_TEACH     2
`define SIC_CTRL_REPEATABLE_TEACH   3
`define SIC_CTRL_RST        32'h0000_0000
`define SIC_CTRL_MASK       32'h0000_000F

// status word fields
`define SIC_ST_SAFETY_A     0
`define SIC_ST_SAFETY_B     1
`define SIC_ST_SOLENOID     2
`define SIC_ST_LED_GREEN    3
`define SIC_ST_LED_YELLOW   4
`define SIC_ST_LED_RED      5
`define SIC_ST_DIAG         6
`define SIC_ST_ERROR        7
`define SIC_ST_LOCKOUT      8
`define SIC_ST_WARNING      9
`define SIC_ST_INHIBIT      10
`define SIC_ST_CODE_VALID   11
`define SIC_ST_STATE_LSB    12
`define SIC_ST_FLASH_LSB    16

// flash codes of the red indicator
`define SIC_FL_OUT_A        4'h1
`define SIC_FL_OUT_B        4'h2
`define SIC_FL_CROSS        4'h3
`define SIC_FL_TEMP         4'h4
`define SIC_FL_ACTUATOR     4'h5
`define SIC_FL_STEADY       4'hF

// timing
`define SIC_CLK_HZ          10000000
`define SIC_TICK_MS         1
`define SIC_TICK_CYC        (`SIC_CLK_HZ / 1000 * `SIC_TICK_MS)
`define SIC_MS_W            21
`define SIC_TEACH_S         10
`define SIC_TEACH_MS        (`SIC_TEACH_S * 1000)
`define SIC_POWEROFF_MIN    5
`define SIC_POWEROFF_MS     (`SIC_POWEROFF_MIN * 60000)
`define SIC_INHIBIT_MIN     10
`define SIC_INHIBIT_MS      (`SIC_INHIBIT_MIN * 60000)
`define SIC_WARN_MIN        30
`define SIC_WARN_MS         (`SIC_WARN_MIN * 60000)
`define SIC_BLINK1_HZ       1
`define SIC_BLINK1_MS       (1000 / `SIC_BLINK1_HZ)
`define SIC_BLINK3_HZ       3
`define SIC_BLINK3_MS       (1000 / `SIC_BLINK3_HZ)
`define SIC_BLINK3_ON_MS    50
`define SIC_FLASH_STEP_MS   250

`endif

// ==== testbench/sic_plc_model.sv ====
// Purpose: safety controller side: drives the lock command, watches outputs
// Assumes: command changes only right after a rising edge
// Notes:   not reset by the device power cycle, as a real controller
`timescale 1ns/100ps
module sic_plc_model (
  input  wire pclk,
  input  wire cmd_req,
  input  wire safety_output_a,
  input  wire safety_output_b,
  output reg  lock_cmd_in,
  output reg  disagree
);
  initial begin
    lock_cmd_in = 1'b0;
    disagree = 1'b0;
  end
  // dual-channel input: a discrepancy seen at any single edge latches disagree
  always @(posedge pclk) begin
    lock_cmd_in <= cmd_req;
    if (safety_output_a !== safety_output_b) disagree <= 1'b1;
  end
endmodule // sic_plc_model

// ==== testbench/sic_top_asserts.sv ====
// Purpose: port-level checker of the interlock control block
// Assumes: zero-wait APB, one clock domain, presetn is the power cycle
// Notes:   tracks the control word from APB writes to know the variant
`timescale 1ns/100ps
module sic_top_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire        pready,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        actuator_present,
  input wire        guard_closed,
  input wire        lock_cmd_in,
  input wire        internal_fault,
  input wire        out_a_fault,
  input wire        out_b_fault,
  input wire        cross_short,
  input wire        nv_inhibit,
  input wire        safety_output_a,
  input wire        safety_output_b,
  input wire        solenoid_drive
);
  reg [3:0] ctrl_q;
  reg       lko;
  reg       err;
  reg [1:0] up;
  wire      eng = ctrl_q[0] ? !lock_cmd_in : lock_cmd_in;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // error model clears early on opening: conservative, outputs are off then anyway
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 4'h0;
      lko <= 1'b0;
      err <= 1'b0;
      up <= 2'h0;
    end else begin
      if (psel && penable && pready && pwrite && paddr == 12'h000) ctrl_q <= pwdata[3:0];
      if (cross_short || (out_a_fault && out_b_fault)) lko <= 1'b1;
      if (internal_fault) err <= 1'b1;
      else if (!guard_closed) err <= 1'b0;
      if (up != 2'h3) up <= up + 2'h1;
    end
  end
  a_fault_drops_out: assert property (internal_fault |=> !safety_output_a && !safety_output_b)
    else $error("safety output on after internal fault");
  a_lockout_holds: assert property (lko |-> !safety_output_a && !safety_output_b)
    else $error("safety output on in lockout");
  a_error_holds: assert property (err |-> !safety_output_a)
    else $error("safety output on before acknowledge");
  a_solenoid_follows: assert property (up == 2'h3 |-> solenoid_drive == $past(lock_cmd_in))
    else $error("solenoid does not follow command");
  a_unlock_drops: assert property (!ctrl_q[1] && !eng |=> !safety_output_a)
    else $error("safety output on while unlocked");
  a_guard_open_drops: assert property (ctrl_q[1] && !guard_closed |=> !safety_output_b)
    else $error("safety output on with guard open");
  a_absent_drops: assert property (!actuator_present |=> !safety_output_a)
    else $error("safety output on without actuator");
  a_inhibit_off: assert property (nv_inhibit |=> !safety_output_b)
    else $error("safety output on during inhibit");
  c_fault: cover property (internal_fault);
  c_inhibit: cover property ($rose(nv_inhibit));
  c_enable: cover property ($rose(safety_output_a));
endmodule // sic_top_chk
bind sic_top sic_top_chk u_sic_top_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata),
  .actuator_present(actuator_present), .guard_closed(guard_closed),
  .lock_cmd_in(lock_cmd_in), .internal_fault(internal_fault), .out_a_fault(out_a_fault),
  .out_b_fault(out_b_fault), .cross_short(cross_short), .nv_inhibit(nv_inhibit),
  .safety_output_a(safety_output_a), .safety_output_b(safety_output_b),
  .solenoid_drive(solenoid_drive));

// ==== testbench/sic_top_bench.sv ====
// Purpose: self-checking bench of the interlock control block
// Assumes: short timer parameters, one tick is TK clock cycles
// Notes:   persistent store modelled by feeding nv outputs back
`timescale 1ns/100ps
module sic_top_bench;
  localparam TK = 10;
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0000_0000, rdata;
  reg act = 1'b0, gc = 1'b0, lk = 1'b0, ifl = 1'b0, fa = 1'b0, fb = 1'b0, cs = 1'b0;
  reg ot = 1'b0, ncv = 1'b0, npv = 1'b0, nih = 1'b0, perr;
  reg [7:0] code = 8'h00, nci = 8'h00, npc = 8'h00;
  wire [31:0] prdata;
  wire [7:0] nc, np;
  wire pready, pslverr, nv_cv, nv_pv, nv_ih, nv_wr, sa, sb, lci, dis;
  integer n_fail = 0, total_checks = 0, cyc = 0, k;
  sic_top #(.TICK_CYC(TK), .TEACH_MS(5), .POWEROFF_MS(10), .INHIBIT_MS(10), .WARN_MS(10))
  u_sic_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .actuator_present(act), .actuator_code(code), .guard_closed(gc),
    .lock_cmd_in(lci), .internal_fault(ifl), .out_a_fault(fa), .out_b_fault(fb),
    .cross_short(cs), .over_temp(ot), .nv_code_in(nci), .nv_code_valid_in(ncv),
    .nv_pend_code_in(npc), .nv_pend_valid_in(npv), .nv_inhibit_in(nih), .nv_code(nc),
    .nv_code_valid(nv_cv), .nv_pend_code(np), .nv_pend_valid(nv_pv), .nv_inhibit(nv_ih),
    .nv_write(nv_wr), .safety_output_a(sa), .safety_output_b(sb), .solenoid_drive(),
    .diag_out(), .led_green(), .led_yellow(), .led_red());
  sic_plc_model u_sic_plc_model (.pclk(pclk), .cmd_req(lk), .safety_output_a(sa),
    .safety_output_b(sb), .lock_cmd_in(lci), .disagree(dis));
  initial begin
    forever #50 pclk = ~pclk;
  end
  // store keeps what was last written while powered
  always @(posedge pclk) begin
    if (presetn && nv_wr) begin
      nci <= nc;
      ncv <= nv_cv;
      npc <= np;
      npv <= nv_pv;
      nih <= nv_ih;
    end
  end
  task results;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      results;
    end
  end
  task chk(input [31:0] g, input [31:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task ap(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 50) begin
        @(posedge pclk);
        k = k + 1;
      end
      chk({31'h0000_0000, pready}, 32'h0000_0001);
      rdata = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge so a following call never drives psel twice in one step
      @(posedge pclk);
    end
  endtask
  task st(input [31:0] m, input [31:0] e);
    begin
      ap(1'b0, 12'h004, 32'h0000_0000);
      chk(rdata & m, e);
    end
  endtask
  task wt(input integer n);
    repeat (n * TK) @(posedge pclk);
  endtask
  task so(input e);
    begin
      #1 chk({30'h0000_0000, sb, sa}, {30'h0000_0000, e, e});
      @(posedge pclk);
    end
  endtask
  task pc;
    begin
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
    end
  endtask
  task gcy;
    begin
      gc <= 1'b0;
      wt(1);
      gc <= 1'b1;
      wt(1);
    end
  endtask
  initial begin
    pc;
    ap(1'b0, 12'h000, 32'h0000_0000);
    chk(rdata, 32'h0000_0000);
    ap(1'b0, 12'h00C, 32'h0000_0000);
    chk({perr, rdata[30:0]}, 32'h8000_0000);
    act <= 1'b1;
    gc <= 1'b1;
    lk <= 1'b1;
    wt(1);
    so(1'b1);
    lk <= 1'b0;
    wt(1);
    so(1'b0);
    lk <= 1'b1;
    wt(1);
    so(1'b1);
    ap(1'b1, 12'h000, 32'h0000_0001);
    so(1'b0);
    lk <= 1'b0;
    wt(1);
    so(1'b1);
    ap(1'b1, 12'h000, 32'h0000_0000);
    wt(1);
    so(1'b0);
    ap(1'b1, 12'h000, 32'h0000_0003);
    lk <= 1'b1;
    wt(1);
    so(1'b1);
    gc <= 1'b0;
    wt(1);
    so(1'b0);
    gc <= 1'b1;
    ap(1'b1, 12'h000, 32'h0000_0000);
    wt(1);
    so(1'b1);
    ifl <= 1'b1;
    wt(1);
    so(1'b0);
    ifl <= 1'b0;
    wt(1);
    so(1'b0);
    gcy;
    so(1'b1);
    st(32'h0000_0078, 32'h0000_0058);
    ot <= 1'b1;
    wt(5);
    so(1'b1);
    st(32'h000F_0241, 32'h0004_0201);
    wt(7);
    so(1'b0);
    ot <= 1'b0;
    gcy;
    so(1'b1);
    cs <= 1'b1;
    wt(1);
    cs <= 1'b0;
    gcy;
    so(1'b0);
    pc;
    wt(1);
    so(1'b1);
    act <= 1'b0;
    code <= 8'h5A;
    pc;
    ap(1'b1, 12'h000, 32'h0000_0008);
    act <= 1'b1;
    wt(1);
    st(32'h0000_7028, 32'h0000_2020);
    wt(6);
    st(32'h0000_7000, 32'h0000_3000);
    act <= 1'b0;
    pc;
    ap(1'b1, 12'h000, 32'h0000_0008);
    act <= 1'b1;
    wt(1);
    st(32'h0000_0C00, 32'h0000_0C00);
    ap(1'b0, 12'h008, 32'h0000_0000);
    chk(rdata & 32'h0000_00FF, 32'h0000_005A);
    so(1'b0);
    wt(4);
    pc;
    ap(1'b1, 12'h000, 32'h0000_0008);
    wt(8);
    so(1'b0);
    wt(5);
    so(1'b1);
    act <= 1'b0;
    code <= 8'hA5;
    pc;
    ap(1'b1, 12'h000, 32'h0000_0008);
    act <= 1'b1;
    wt(19);
    st(32'h000F_7000, 32'h0005_1000);
    act <= 1'b0;
    pc;
    ap(1'b1, 12'h000, 32'h0000_0004);
    act <= 1'b1;
    wt(2);
    st(32'h0000_7000, 32'h0000_1000);
    chk({31'h0000_0000, dis}, 32'h0000_0000);
    results;
  end
endmodule // sic_top_bench

// ==== verilog/sic_top.v ====
// Purpose: door interlock solenoid control, teach-in, inhibit, safety outputs
// Assumes: presetn is the power cycle; nv_* inputs hold the persistent store
// Notes:   all inputs synchronous to pclk; APB answers with zero wait states
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "sic_regs.vh"

// What this block does
// - power-up new actuator starts teach, LEDs shown
// - after ten seconds yellow blinks three hertz
// - no power-off in five minutes aborts, five flashes
// - new code activates when detected after power-up
// - one-time variant refuses teach after first pairing
// - repeatable variant teaches again, old code dropped
// - safety outputs inhibited ten minutes after learning
// - green blinks until inhibit over and actuator seen
// - power loss restarts inhibit period from zero
// - unlock-on-energise: command high releases lock
// - lock-on-energise: command high engages lock
// - standard variant: unlocking disables safety outputs
// - relock with actuator inserted re-enables outputs
// - guard-position variant: opening guard disables outputs
// - green supply, yellow condition, red blink codes
// - internal error disables outputs at once
// - error clears only after guard opened, closed
// - double output fault or cross short latches lockout
// - lockout leaves only through a power cycle
// - standard coding accepts actuator without teach
// - warning held thirty minutes switches outputs off
module sic_top #(
  parameter CODE_W      = 8,
  parameter TICK_CYC    = `SIC_TICK_CYC,
  parameter TEACH_MS    = `SIC_TEACH_MS,
  parameter POWEROFF_MS = `SIC_POWEROFF_MS,
  parameter INHIBIT_MS  = `SIC_INHIBIT_MS,
  parameter WARN_MS     = `SIC_WARN_MS
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  input  wire              actuator_present,
  input  wire [CODE_W-1:0] actuator_code,
  input  wire              guard_closed,
  input  wire              lock_cmd_in,
  input  wire              internal_fault,
  input  wire              out_a_fault,
  input  wire              out_b_fault,
  input  wire              cross_short,
  input  wire              over_temp,
  input  wire [CODE_W-1:0] nv_code_in,
  input  wire              nv_code_valid_in,
  input  wire [CODE_W-1:0] nv_pend_code_in,
  input  wire              nv_pend_valid_in,
  input  wire              nv_inhibit_in,
  output reg  [CODE_W-1:0] nv_code,
  output reg               nv_code_valid,
  output reg  [CODE_W-1:0] nv_pend_code,
  output reg               nv_pend_valid,
  output reg               nv_inhibit,
  output reg               nv_write,
  output reg               safety_output_a,
  output reg               safety_output_b,
  output reg               solenoid_drive,
  output reg               diag_out,
  output reg               led_green,
  output reg               led_yellow,
  output reg               led_red
);

  localparam MSW = `SIC_MS_W;
  localparam [2:0] ST_LOAD = 3'h0, ST_RUN = 3'h1, ST_TEACH = 3'h2, ST_REQ = 3'h3;
  localparam [31:0] DIV_W = TICK_CYC - 1, TEACH_W = TEACH_MS, PWROFF_W = POWEROFF_MS;
  localparam [31:0] INH_W = INHIBIT_MS, WARN_W = WARN_MS, B1_W = `SIC_BLINK1_MS - 1;
  localparam [31:0] B1H_W = `SIC_BLINK1_MS / 2, B3_W = `SIC_BLINK3_MS - 1;
  localparam [31:0] B3ON_W = `SIC_BLINK3_ON_MS, STEP_W = `SIC_FLASH_STEP_MS - 1;
  // full-width values above, cut on purpose to the counter widths here
  localparam [MSW-1:0] TEACH_END = TEACH_W[MSW-1:0];
  localparam [MSW-1:0] PWROFF_END = PWROFF_W[MSW-1:0];
  localparam [MSW-1:0] INH_END = INH_W[MSW-1:0];
  localparam [MSW-1:0] WARN_END = WARN_W[MSW-1:0];
  localparam [13:0] DIV_END = DIV_W[13:0];
  localparam [9:0] B1_END = B1_W[9:0];
  localparam [9:0] B1_HALF = B1H_W[9:0];
  localparam [9:0] B3_END = B3_W[9:0];
  localparam [9:0] B3_ON = B3ON_W[9:0];
  localparam [9:0] STEP_END = STEP_W[9:0];
  reg  [31:0]       ctrl_reg;
  reg  [2:0]        state_reg;
  reg  [13:0]       div_reg;
  reg  [MSW-1:0]    tmr_reg;
  reg  [MSW-1:0]    inh_cnt_reg;
  reg  [MSW-1:0]    warn_cnt_reg;
  reg  [9:0]        b1_reg, b3_reg, step_ms_reg;
  reg  [3:0]        step_reg;
  reg               fresh_reg;
  reg               green_blink_reg;
  reg               error_reg;
  reg  [3:0]        err_code_reg;
  reg               err_open_reg;
  reg               lockout_reg;
  reg  [31:0]       rd_mux;
  reg  [3:0]        warn_code;
  reg               red_next, yellow_next, green_next;
  wire tick = (div_reg == DIV_END);
  wire unl_var = ctrl_reg[`SIC_CTRL_UNLOCK_ON_ENERGISE];
  wire gpos_var = ctrl_reg[`SIC_CTRL_GUARD_POSITION];
  wire one_time_teach_variant = ctrl_reg[`SIC_CTRL_ONE_TIME_TEACH];
  wire repeatable_teach_variant = ctrl_reg[`SIC_CTRL_REPEATABLE_TEACH];
  wire std_coding = !one_time_teach_variant && !repeatable_teach_variant;
  wire act_match = actuator_present && nv_code_valid && (actuator_code == nv_code);
  wire act_ok = actuator_present && (std_coding || act_match);
  // polarity of the command decides what energising means
  wire lock_engaged = unl_var ? !lock_cmd_in : lock_cmd_in;
  wire teach_allowed = !std_coding && !(one_time_teach_variant && nv_code_valid);
  wire lock_cause = cross_short || (out_a_fault && out_b_fault);
  wire warn_cause = out_a_fault || out_b_fault || over_temp;
  wire pend_hit = nv_pend_valid && actuator_present && (actuator_code == nv_pend_code);
  wire enable_cond = act_ok && guard_closed && (gpos_var || lock_engaged)
                     && !nv_inhibit && !error_reg && !lockout_reg
                     && !internal_fault && !lock_cause && (state_reg == ST_RUN);
  wire blink1 = (b1_reg < B1_HALF);
  wire short3 = (b3_reg < B3_ON);
  wire setup_ph = psel && !penable;
  wire wr_ctrl = psel && penable && pwrite && pready && (paddr == `SIC_CTRL_OFS);
  function flash_on;
    input [3:0] step;
    input [3:0] n;
    begin
      flash_on = !step[0] && ({1'b0, step[3:1]} < n);
    end
  endfunction
  always @* begin
    warn_code = 4'h0;
    if (cross_short || (out_a_fault && out_b_fault)) begin
      warn_code = `SIC_FL_CROSS;
    end else if (out_a_fault) begin
      warn_code = `SIC_FL_OUT_A;
    end else if (out_b_fault) begin
      warn_code = `SIC_FL_OUT_B;
    end else if (over_temp) begin
      warn_code = `SIC_FL_TEMP;
    end
  end

  always @* begin
    green_next = 1'b1;
    yellow_next = 1'b0;
    red_next = 1'b0;
    if (state_reg == ST_TEACH) begin
      green_next = 1'b0;
      yellow_next = blink1;
      red_next = 1'b1;
    end else if (state_reg == ST_REQ) begin
      green_next = 1'b0;
      yellow_next = short3;
      red_next = 1'b1;
    end else begin
      if (green_blink_reg) begin
        green_next = blink1;
      end
      yellow_next = enable_cond ? 1'b1 : (act_ok ? blink1 : 1'b0);
      if (lockout_reg) begin
        red_next = 1'b1;
      end else if (error_reg) begin
        red_next = (err_code_reg == `SIC_FL_STEADY) ? 1'b1 : flash_on(step_reg, err_code_reg);
      end else if (warn_cause) begin
        red_next = flash_on(step_reg, warn_code);
      end
    end
  end

  always @* begin
    rd_mux = 32'h0000_0000;
    if (paddr == `SIC_CTRL_OFS) begin
      rd_mux = ctrl_reg;
    end else if (paddr == `SIC_STATUS_OFS) begin
      rd_mux[`SIC_ST_SAFETY_A] = safety_output_a;
      rd_mux[`SIC_ST_SAFETY_B] = safety_output_b;
      rd_mux[`SIC_ST_SOLENOID] = solenoid_drive;
      rd_mux[`SIC_ST_LED_GREEN] = led_green;
      rd_mux[`SIC_ST_LED_YELLOW] = led_yellow;
      rd_mux[`SIC_ST_LED_RED] = led_red;
      rd_mux[`SIC_ST_DIAG] = diag_out;
      rd_mux[`SIC_ST_ERROR] = error_reg;
      rd_mux[`SIC_ST_LOCKOUT] = lockout_reg;
      rd_mux[`SIC_ST_WARNING] = warn_cause;
      rd_mux[`SIC_ST_INHIBIT] = nv_inhibit;
      rd_mux[`SIC_ST_CODE_VALID] = nv_code_valid;
      rd_mux[`SIC_ST_STATE_LSB+2:`SIC_ST_STATE_LSB] = state_reg;
      rd_mux[`SIC_ST_FLASH_LSB+3:`SIC_ST_FLASH_LSB] = error_reg ? err_code_reg : warn_code;
    end else if (paddr == `SIC_CODE_OFS) begin
      rd_mux[CODE_W-1:0] = nv_code;
    end
  end

  // apb slave: data latched in setup, answered in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `SIC_CTRL_RST;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ph;
      if (setup_ph) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= (paddr != `SIC_CTRL_OFS) && (paddr != `SIC_STATUS_OFS)
                   && (paddr != `SIC_CODE_OFS);
      end
      if (wr_ctrl) begin
        ctrl_reg <= pwdata & `SIC_CTRL_MASK;
      end
    end
  end

  // timebase and blink phases
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 14'h0000;
      b1_reg <= 10'h000;
      b3_reg <= 10'h000;
      step_ms_reg <= 10'h000;
      step_reg <= 4'h0;
    end else begin
      div_reg <= tick ? 14'h0000 : div_reg + 14'h0001;
      if (tick) begin
        b1_reg <= (b1_reg == B1_END) ? 10'h000 : b1_reg + 10'h001;
        b3_reg <= (b3_reg == B3_END) ? 10'h000 : b3_reg + 10'h001;
        step_ms_reg <= (step_ms_reg == STEP_END) ? 10'h000 : step_ms_reg + 10'h001;
        if (step_ms_reg == STEP_END) begin
          step_reg <= step_reg + 4'h1;
        end
      end
    end
  end

  // errors, warnings and lockout
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_reg <= 1'b0;
      err_code_reg <= 4'h0;
      err_open_reg <= 1'b0;
      lockout_reg <= 1'b0;
      warn_cnt_reg <= {MSW{1'b0}};
    end else begin
      if (lock_cause) begin
        lockout_reg <= 1'b1;
      end
      if (!warn_cause) begin
        warn_cnt_reg <= {MSW{1'b0}};
      end else if (tick && (warn_cnt_reg != WARN_END)) begin
        warn_cnt_reg <= warn_cnt_reg + {{(MSW-1){1'b0}}, 1'b1};
      end
      // set terms come first so a new fault beats the acknowledge
      if (internal_fault) begin
        error_reg <= 1'b1;
        err_code_reg <= `SIC_FL_STEADY;
        err_open_reg <= 1'b0;
      end else if (warn_cause && (warn_cnt_reg == WARN_END)) begin
        error_reg <= 1'b1;
        err_code_reg <= warn_code;
        err_open_reg <= 1'b0;
      end else if ((state_reg == ST_REQ) && tick && (tmr_reg == PWROFF_END)) begin
        error_reg <= 1'b1;
        err_code_reg <= `SIC_FL_ACTUATOR;
        err_open_reg <= 1'b0;
      end else if (error_reg && !warn_cause) begin
        if (!guard_closed) begin
          err_open_reg <= 1'b1;
        end else if (err_open_reg) begin
          error_reg <= 1'b0;
          err_code_reg <= 4'h0;
          err_open_reg <= 1'b0;
        end
      end
    end
  end

  // teach-in sequence and persistent pairing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_LOAD;
      tmr_reg <= {MSW{1'b0}};
      inh_cnt_reg <= {MSW{1'b0}};
      fresh_reg <= 1'b0;
      green_blink_reg <= 1'b0;
      nv_code <= {CODE_W{1'b0}};
      nv_code_valid <= 1'b0;
      nv_pend_code <= {CODE_W{1'b0}};
      nv_pend_valid <= 1'b0;
      nv_inhibit <= 1'b0;
      nv_write <= 1'b0;
    end else begin
      nv_write <= 1'b0;
      if (nv_inhibit && tick) begin
        if (inh_cnt_reg == INH_END) begin
          nv_inhibit <= 1'b0;
          nv_write <= 1'b1;
        end else begin
          inh_cnt_reg <= inh_cnt_reg + {{(MSW-1){1'b0}}, 1'b1};
        end
      end
      if (green_blink_reg && !nv_inhibit && act_match) begin
        green_blink_reg <= 1'b0;
      end
      case (state_reg)
        ST_LOAD: begin
          // store restored one edge after release
          nv_code <= nv_code_in;
          nv_code_valid <= nv_code_valid_in;
          nv_pend_code <= nv_pend_code_in;
          nv_pend_valid <= nv_pend_valid_in;
          nv_inhibit <= nv_inhibit_in;
          inh_cnt_reg <= {MSW{1'b0}};
          green_blink_reg <= nv_inhibit_in;
          fresh_reg <= 1'b1;
          state_reg <= ST_RUN;
        end
        ST_RUN: begin
          if (actuator_present && fresh_reg) begin
            fresh_reg <= 1'b0;
            if (pend_hit && teach_allowed) begin
              nv_code <= nv_pend_code;
              nv_code_valid <= 1'b1;
              nv_pend_valid <= 1'b0;
              nv_inhibit <= 1'b1;
              inh_cnt_reg <= {MSW{1'b0}};
              green_blink_reg <= 1'b1;
              nv_write <= 1'b1;
            end else if (teach_allowed && !act_match) begin
              nv_pend_code <= actuator_code;
              tmr_reg <= {MSW{1'b0}};
              state_reg <= ST_TEACH;
            end
          end
        end
        ST_TEACH: begin
          // pulling the actuator early drops the attempt quietly
          if (!actuator_present) begin
            state_reg <= ST_RUN;
          end else if (tick) begin
            if (tmr_reg == TEACH_END) begin
              tmr_reg <= {MSW{1'b0}};
              nv_pend_valid <= 1'b1;
              nv_write <= 1'b1;
              state_reg <= ST_REQ;
            end else begin
              tmr_reg <= tmr_reg + {{(MSW-1){1'b0}}, 1'b1};
            end
          end
        end
        ST_REQ: begin
          if (tick) begin
            if (tmr_reg == PWROFF_END) begin
              nv_pend_valid <= 1'b0;
              nv_write <= 1'b1;
              state_reg <= ST_RUN;
            end else begin
              tmr_reg <= tmr_reg + {{(MSW-1){1'b0}}, 1'b1};
            end
          end
        end
        default: begin
          state_reg <= ST_RUN;
        end
      endcase
    end
  end

  // pins, all registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      safety_output_a <= 1'b0;
      safety_output_b <= 1'b0;
      solenoid_drive <= 1'b0;
      diag_out <= 1'b0;
      led_green <= 1'b0;
      led_yellow <= 1'b0;
      led_red <= 1'b0;
    end else begin
      safety_output_a <= enable_cond;
      safety_output_b <= enable_cond;
      solenoid_drive <= lock_cmd_in;
      // not a safety signal: drops early on warnings
      diag_out <= enable_cond && !warn_cause;
      led_green <= green_next;
      led_yellow <= yellow_next;
      led_red <= red_next;
    end
  end

endmodule // sic_top
